/* File: rtl/vic_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none

// Operation
// (R1) Main enable bit 7 gates every source; cleared means nothing is serviced.
// (R2) Main enable bits 6..0 enable adc, timer2, uart, timer1, ext1, timer0, ext0.
// (R3) Main priority bits 6..0 pick high or low level; bit 7 reserved.
// (R4) Secondary bits 6,5,4 set interval counter, supply monitor, serial port priority.
// (R5) Secondary bits 2,1,0 enable interval counter, supply monitor, serial port.
// (R6) Software keeps secondary bit 3 at zero.
// (R7) Secondary resets to A0 and is byte-only; main registers reset 00, bit-addressable.
// (R8) High-level request may preempt a running low-level routine.
// (R9) Simultaneous requests of both levels: high level vectored first.
// (R10) No new request of a level while that level is in service.
// (R11) Same-level ties resolved by fixed polling order, supply monitor first.
// (R12) Acceptance pulses a program counter push and supplies the vector.
// (R13) Each source has its own fixed vector address.
// (R14) Return frees the active level; equal or lower requests eligible again.
module vic_ctrl (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic [7:0] bit_addr,
   input wire logic bit_wr,
   input wire logic bit_wdata,
   input wire logic ext0_request,
   input wire logic ext1_request,
   input wire logic timer0_overflow_request,
   input wire logic timer1_overflow_request,
   input wire logic timer2_overflow_request,
   input wire logic timer2_external_request,
   input wire logic uart_rx_request,
   input wire logic uart_tx_request,
   input wire logic adc_request,
   input wire logic serial_port_request,
   input wire logic supply_monitor_request,
   input wire logic watchdog_request,
   input wire logic interval_counter_request,
   input wire logic core_ready,
   input wire logic core_return,
   output logic irq_take,
   output logic [15:0] irq_vector,
   output logic irq_take_high,
   output logic low_in_service,
   output logic high_in_service
);

   localparam int NS = vic_pkg::NUM_SRC;
   localparam int IW = $clog2(NS);

   logic [7:0] irq_enable_main;
   logic [7:0] irq_priority_main;
   logic [7:0] irq_enable_priority_secondary;
   vic_pkg::vic_svc_t svc;
   vic_pkg::vic_svc_t next_svc;

   logic [NS-1:0] src_req;
   logic [NS-1:0] src_en;
   logic [NS-1:0] src_pri;
   logic [NS-1:0] elig_high;
   logic [NS-1:0] elig_low;
   logic [NS-1:0] pick_req;
   logic pick_any;
   logic [IW-1:0] pick_idx;
   logic high_busy;
   logic low_busy;
   logic accept;

   // Register file: byte writes, plus bit writes into the two main registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         irq_enable_main <= vic_pkg::RST_ENABLE_MAIN; // see (R7)
         irq_priority_main <= vic_pkg::RST_PRIORITY_MAIN; // see (R7)
         irq_enable_priority_secondary <= vic_pkg::RST_ENABLE_PRIORITY_SECONDARY; // see (R7)
      end else begin
         if (sfr_wr) begin
            case (sfr_addr)
               vic_pkg::ADDR_ENABLE_MAIN: irq_enable_main <= sfr_wdata;
               vic_pkg::ADDR_PRIORITY_MAIN: irq_priority_main <= sfr_wdata;
               vic_pkg::ADDR_ENABLE_PRIORITY_SECONDARY: begin
                  // Stored as written; bit 3 is left to software to keep clear
                  irq_enable_priority_secondary <= sfr_wdata; // see (R6)
               end
               default: ;
            endcase
         end
         // Secondary register has no bit address, so only the main ones here
         if (bit_wr && bit_addr[7:3] == vic_pkg::BITBASE_ENABLE_MAIN) begin
            irq_enable_main[bit_addr[2:0]] <= bit_wdata; // see (R7)
         end
         if (bit_wr && bit_addr[7:3] == vic_pkg::BITBASE_PRIORITY_MAIN) begin
            irq_priority_main[bit_addr[2:0]] <= bit_wdata; // see (R7)
         end
      end
   end

   // Registered read-back, zero for unmapped addresses
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sfr_rdata <= vic_pkg::RDATA_UNMAPPED;
      end else begin
         case (sfr_addr)
            vic_pkg::ADDR_ENABLE_MAIN: sfr_rdata <= irq_enable_main;
            vic_pkg::ADDR_PRIORITY_MAIN: sfr_rdata <= irq_priority_main;
            vic_pkg::ADDR_ENABLE_PRIORITY_SECONDARY: sfr_rdata <= irq_enable_priority_secondary;
            default: sfr_rdata <= vic_pkg::RDATA_UNMAPPED;
         endcase
      end
   end

   // Requests, enables and levels mapped into polling order
   always_comb begin
      src_req = '0;
      src_en = '0;
      src_pri = '0;
      src_req[vic_pkg::SRC_SUPPLY_MONITOR] = supply_monitor_request;
      src_req[vic_pkg::SRC_WATCHDOG] = watchdog_request;
      src_req[vic_pkg::SRC_EXT0] = ext0_request;
      src_req[vic_pkg::SRC_ADC] = adc_request;
      src_req[vic_pkg::SRC_TIMER0] = timer0_overflow_request;
      src_req[vic_pkg::SRC_EXT1] = ext1_request;
      src_req[vic_pkg::SRC_TIMER1] = timer1_overflow_request;
      src_req[vic_pkg::SRC_SERIAL_PORT] = serial_port_request;
      src_req[vic_pkg::SRC_UART] = uart_rx_request | uart_tx_request;
      src_req[vic_pkg::SRC_TIMER2] = timer2_overflow_request | timer2_external_request;
      src_req[vic_pkg::SRC_INTERVAL_COUNTER] = interval_counter_request;

      src_en[vic_pkg::SRC_ADC] = irq_enable_main[vic_pkg::BIT_ADC]; // see (R2)
      src_en[vic_pkg::SRC_TIMER2] = irq_enable_main[vic_pkg::BIT_TIMER2]; // see (R2)
      src_en[vic_pkg::SRC_UART] = irq_enable_main[vic_pkg::BIT_UART]; // see (R2)
      src_en[vic_pkg::SRC_TIMER1] = irq_enable_main[vic_pkg::BIT_TIMER1]; // see (R2)
      src_en[vic_pkg::SRC_EXT1] = irq_enable_main[vic_pkg::BIT_EXT1]; // see (R2)
      src_en[vic_pkg::SRC_TIMER0] = irq_enable_main[vic_pkg::BIT_TIMER0]; // see (R2)
      src_en[vic_pkg::SRC_EXT0] = irq_enable_main[vic_pkg::BIT_EXT0]; // see (R2)
      src_en[vic_pkg::SRC_INTERVAL_COUNTER] =
         irq_enable_priority_secondary[vic_pkg::BIT_INTERVAL_COUNTER_ENABLE]; // see (R5)
      src_en[vic_pkg::SRC_SUPPLY_MONITOR] =
         irq_enable_priority_secondary[vic_pkg::BIT_SUPPLY_MONITOR_ENABLE]; // see (R5)
      src_en[vic_pkg::SRC_SERIAL_PORT] =
         irq_enable_priority_secondary[vic_pkg::BIT_SERIAL_PORT_ENABLE]; // see (R5)
      src_en[vic_pkg::SRC_WATCHDOG] = vic_pkg::WATCHDOG_ENABLE;

      src_pri[vic_pkg::SRC_ADC] = irq_priority_main[vic_pkg::BIT_ADC]; // see (R3)
      src_pri[vic_pkg::SRC_TIMER2] = irq_priority_main[vic_pkg::BIT_TIMER2]; // see (R3)
      src_pri[vic_pkg::SRC_UART] = irq_priority_main[vic_pkg::BIT_UART]; // see (R3)
      src_pri[vic_pkg::SRC_TIMER1] = irq_priority_main[vic_pkg::BIT_TIMER1]; // see (R3)
      src_pri[vic_pkg::SRC_EXT1] = irq_priority_main[vic_pkg::BIT_EXT1]; // see (R3)
      src_pri[vic_pkg::SRC_TIMER0] = irq_priority_main[vic_pkg::BIT_TIMER0]; // see (R3)
      src_pri[vic_pkg::SRC_EXT0] = irq_priority_main[vic_pkg::BIT_EXT0]; // see (R3)
      src_pri[vic_pkg::SRC_INTERVAL_COUNTER] =
         irq_enable_priority_secondary[vic_pkg::BIT_INTERVAL_COUNTER_PRIORITY]; // see (R4)
      src_pri[vic_pkg::SRC_SUPPLY_MONITOR] =
         irq_enable_priority_secondary[vic_pkg::BIT_SUPPLY_MONITOR_PRIORITY]; // see (R4)
      src_pri[vic_pkg::SRC_SERIAL_PORT] =
         irq_enable_priority_secondary[vic_pkg::BIT_SERIAL_PORT_PRIORITY]; // see (R4)
      src_pri[vic_pkg::SRC_WATCHDOG] = vic_pkg::WATCHDOG_PRIORITY;
   end

   assign high_busy = (svc == vic_pkg::VIC_SVC_HIGH) || (svc == vic_pkg::VIC_SVC_LOW_HIGH);
   assign low_busy = (svc != vic_pkg::VIC_SVC_IDLE);

   // Master gate, then level blocking: a busy level shuts out its own kind
   always_comb begin
      elig_high = '0;
      elig_low = '0;
      if (irq_enable_main[vic_pkg::BIT_GLOBAL_IRQ_ENABLE]) begin // see (R1)
         // High waits only for high; low waits for any routine
         if (!high_busy) begin // see (R8) see (R10)
            elig_high = src_req & src_en & src_pri;
         end
         if (!low_busy) begin // see (R10)
            elig_low = src_req & src_en & ~src_pri;
         end
      end
      pick_req = (|elig_high) ? elig_high : elig_low; // see (R9)
   end

   vic_poll_pick #(
      .N(NS)
   ) u_pick (
      .req(pick_req), // see (R11)
      .any(pick_any),
      .idx(pick_idx)
   );

   // A return in the same cycle blocks acceptance, so nesting never tangles
   assign accept = core_ready && pick_any && !core_return && !irq_take;

   always_comb begin
      next_svc = svc;
      case (svc)
         vic_pkg::VIC_SVC_IDLE: begin
            if (accept) begin
               next_svc = (|elig_high) ? vic_pkg::VIC_SVC_HIGH : vic_pkg::VIC_SVC_LOW;
            end
         end
         vic_pkg::VIC_SVC_LOW: begin
            if (core_return) begin
               next_svc = vic_pkg::VIC_SVC_IDLE; // see (R14)
            end else if (accept) begin
               next_svc = vic_pkg::VIC_SVC_LOW_HIGH; // see (R8)
            end
         end
         vic_pkg::VIC_SVC_HIGH: begin
            if (core_return) begin
               next_svc = vic_pkg::VIC_SVC_IDLE; // see (R14)
            end
         end
         vic_pkg::VIC_SVC_LOW_HIGH: begin
            if (core_return) begin
               next_svc = vic_pkg::VIC_SVC_LOW; // see (R14)
            end
         end
         default: next_svc = vic_pkg::VIC_SVC_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         svc <= vic_pkg::VIC_SVC_IDLE;
      end else begin
         svc <= next_svc;
      end
   end

   // Push strobe and vector, one cycle per acceptance
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         irq_take <= 1'b0;
         irq_take_high <= 1'b0;
         irq_vector <= 16'h0000;
      end else begin
         irq_take <= accept; // see (R12)
         if (accept) begin
            irq_take_high <= |elig_high;
            irq_vector <= vic_pkg::VECTOR_TABLE[pick_idx]; // see (R13)
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         low_in_service <= 1'b0;
         high_in_service <= 1'b0;
      end else begin
         low_in_service <= (next_svc == vic_pkg::VIC_SVC_LOW)
            || (next_svc == vic_pkg::VIC_SVC_LOW_HIGH);
         high_in_service <= (next_svc == vic_pkg::VIC_SVC_HIGH)
            || (next_svc == vic_pkg::VIC_SVC_LOW_HIGH);
      end
   end

   property p_gate_blocks;
      @(posedge mclk) disable iff (!arst_n)
         !irq_enable_main[vic_pkg::BIT_GLOBAL_IRQ_ENABLE] |=> !irq_take;
   endproperty
   a_gate_blocks: assert property (p_gate_blocks) // see (R1)
      else $error("take while master gate cleared");

   property p_disabled_source;
      @(posedge mclk) disable iff (!arst_n)
         (core_ready && !core_return && !irq_take && adc_request
          && !irq_enable_main[vic_pkg::BIT_ADC] && ~|(src_req & ~(1 << vic_pkg::SRC_ADC)))
         |=> !irq_take;
   endproperty
   a_disabled_source: assert property (p_disabled_source) // see (R2)
      else $error("disabled adc request was taken");

   property p_reset_values;
      @(posedge mclk) $rose(arst_n) |-> irq_enable_priority_secondary == 8'hA0
         && irq_enable_main == 8'h00 && irq_priority_main == 8'h00;
   endproperty
   a_reset_values: assert property (p_reset_values) // see (R7)
      else $error("register reset value wrong");

   property p_take_when_eligible;
      @(posedge mclk) disable iff (!arst_n)
         (core_ready && !core_return && !irq_take && |elig_high) |=> irq_take && irq_take_high;
   endproperty
   a_take_when_eligible: assert property (p_take_when_eligible) // see (R9) see (R12)
      else $error("eligible high request not taken as high");

   property p_preempt_low;
      @(posedge mclk) disable iff (!arst_n)
         (svc == vic_pkg::VIC_SVC_LOW && accept) |=> high_in_service && low_in_service;
   endproperty
   a_preempt_low: assert property (p_preempt_low) // see (R8)
      else $error("high did not nest over low");

   property p_no_same_level;
      @(posedge mclk) disable iff (!arst_n)
         (irq_take && $past(high_in_service)) |-> !irq_take_high;
   endproperty
   a_no_same_level: assert property (p_no_same_level) // see (R10)
      else $error("second high accepted while high in service");

   property p_supply_first;
      @(posedge mclk) disable iff (!arst_n)
         (accept && pick_req[vic_pkg::SRC_SUPPLY_MONITOR]) |=> irq_vector == 16'h0043;
   endproperty
   a_supply_first: assert property (p_supply_first) // see (R11) see (R13)
      else $error("supply monitor lost polling order");

   property p_return_frees;
      @(posedge mclk) disable iff (!arst_n)
         (svc == vic_pkg::VIC_SVC_HIGH && core_return) |=> !high_in_service;
   endproperty
   a_return_frees: assert property (p_return_frees) // see (R14)
      else $error("return did not free high level");

endmodule : vic_ctrl
`default_nettype wire

/* File: rtl/vic_pkg.sv */
package vic_pkg;

   // Register addresses
   localparam logic [7:0] ADDR_ENABLE_MAIN = 8'hA8;
   localparam logic [7:0] ADDR_ENABLE_PRIORITY_SECONDARY = 8'hA9;
   localparam logic [7:0] ADDR_PRIORITY_MAIN = 8'hB8;

   // Reset values
   localparam logic [7:0] RST_ENABLE_MAIN = 8'h00;
   localparam logic [7:0] RST_ENABLE_PRIORITY_SECONDARY = 8'hA0;
   localparam logic [7:0] RST_PRIORITY_MAIN = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // Bit-address space: base of each bit-addressable register
   localparam logic [4:0] BITBASE_ENABLE_MAIN = 5'h15;
   localparam logic [4:0] BITBASE_PRIORITY_MAIN = 5'h17;

   // Main enable / main priority field positions
   localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
   localparam int BIT_ADC = 6;
   localparam int BIT_TIMER2 = 5;
   localparam int BIT_UART = 4;
   localparam int BIT_TIMER1 = 3;
   localparam int BIT_EXT1 = 2;
   localparam int BIT_TIMER0 = 1;
   localparam int BIT_EXT0 = 0;

   // Secondary register field positions
   localparam int BIT_INTERVAL_COUNTER_PRIORITY = 6;
   localparam int BIT_SUPPLY_MONITOR_PRIORITY = 5;
   localparam int BIT_SERIAL_PORT_PRIORITY = 4;
   localparam int BIT_INTERVAL_COUNTER_ENABLE = 2;
   localparam int BIT_SUPPLY_MONITOR_ENABLE = 1;
   localparam int BIT_SERIAL_PORT_ENABLE = 0;

   // Sources in polling order, index 0 polled first
   localparam int NUM_SRC = 11;
   localparam int SRC_SUPPLY_MONITOR = 0;
   localparam int SRC_WATCHDOG = 1;
   localparam int SRC_EXT0 = 2;
   localparam int SRC_ADC = 3;
   localparam int SRC_TIMER0 = 4;
   localparam int SRC_EXT1 = 5;
   localparam int SRC_TIMER1 = 6;
   localparam int SRC_SERIAL_PORT = 7;
   localparam int SRC_UART = 8;
   localparam int SRC_TIMER2 = 9;
   localparam int SRC_INTERVAL_COUNTER = 10;

   // Watchdog has no enable or priority field
   localparam logic WATCHDOG_ENABLE = 1'b1;
   localparam logic WATCHDOG_PRIORITY = 1'b1;

   // Vector per source, in polling order
   localparam logic [NUM_SRC-1:0][15:0] VECTOR_TABLE = {
      16'h0053, // interval counter
      16'h002B, // timer 2
      16'h0023, // uart
      16'h003B, // serial port
      16'h001B, // timer 1
      16'h0013, // ext 1
      16'h000B, // timer 0
      16'h0033, // adc
      16'h0003, // ext 0
      16'h005B, // watchdog
      16'h0043  // supply monitor
   };

   typedef enum logic [1:0] {
      VIC_SVC_IDLE,
      VIC_SVC_LOW,
      VIC_SVC_HIGH,
      VIC_SVC_LOW_HIGH
   } vic_svc_t;

endpackage : vic_pkg

/* File: rtl/vic_poll_pick.sv */
`timescale 1ns/10ps
`default_nettype none

// Fixed-order picker: lowest set index wins
module vic_poll_pick #(
   parameter int N = 11
) (
   input wire logic [N-1:0] req,
   output logic any,
   output logic [$clog2(N)-1:0] idx
);

   logic [N-1:0] first;

   // One term per entry: set only where no lower entry is set
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_first
         if (g == 0) begin : g_zero
            assign first[g] = req[g];
         end else begin : g_rest
            assign first[g] = req[g] & ~|req[g-1:0];
         end
      end
   endgenerate

   always_comb begin
      idx = '0;
      for (int i = 0; i < N; i++) begin
         if (first[i]) begin
            idx = ($clog2(N))'(i);
         end
      end
   end

   assign any = |req;

endmodule : vic_poll_pick
`default_nettype wire

/* File: sim/vic_core_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Core sequencer stand-in: can hold off acceptance, ends routines on request
module vic_core_model (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic stall,
   input wire logic ret_req,
   input wire logic irq_take,
   input wire logic [15:0] irq_vector,
   output logic core_ready,
   output logic core_return,
   output logic [15:0] pc
);
   logic [1:0] depth;

   assign core_ready = arst_n & ~stall;

   // Nesting is two deep at most: one low, one high
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         depth <= 2'h0;
      end else if (irq_take) begin
         depth <= depth + 2'h1;
      end else if (core_return) begin
         depth <= depth - 2'h1;
      end
   end

   // A real core never returns from a routine it did not enter;
   // a take on this same edge already counts as entered
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         core_return <= 1'b0;
      end else begin
         core_return <= ret_req & ((depth != 2'h0) | irq_take);
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pc <= 16'h0000;
      end else if (irq_take) begin
         pc <= irq_vector;
      end
   end
endmodule : vic_core_model
`default_nettype wire

/* File: sim/vic_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module vic_ctrl_tb;
   typedef struct packed {
      logic [7:0] en;
      logic [7:0] sec;
      logic [7:0] pri;
      logic [12:0] req;
      logic [15:0] vec;
      logic hi;
   } vic_row_t;

   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic [7:0] bit_addr = 8'h00;
   logic bit_wr = 1'b0;
   logic bit_wdata = 1'b0;
   // Request bits: ext0 ext1 t0 t1 t2ovf t2ext rx tx adc serial supply watchdog interval
   logic [12:0] req = 13'h0000;
   logic stall = 1'b0;
   logic ret_req = 1'b0;
   logic core_ready, core_return, irq_take, irq_take_high;
   logic low_in_service, high_in_service;
   logic [15:0] irq_vector;
   int bad_count = 0;
   int num_checks = 0;

   vic_row_t rows[] = '{
      '{8'hFF, 8'h07, 8'h00, 13'h0001, 16'h0003, 1'b0},
      '{8'hFF, 8'h07, 8'h00, 13'h0004, 16'h000B, 1'b0},
      '{8'hFF, 8'h07, 8'h00, 13'h0002, 16'h0013, 1'b0},
      '{8'hFF, 8'h07, 8'h00, 13'h0008, 16'h001B, 1'b0},
      '{8'hFF, 8'h07, 8'h00, 13'h0010, 16'h002B, 1'b0},
      '{8'hFF, 8'h07, 8'h00, 13'h0020, 16'h002B, 1'b0},
      '{8'hFF, 8'h07, 8'h00, 13'h0040, 16'h0023, 1'b0},
      '{8'hFF, 8'h07, 8'h00, 13'h0080, 16'h0023, 1'b0},
      '{8'hFF, 8'h07, 8'h00, 13'h0100, 16'h0033, 1'b0},
      '{8'hFF, 8'h07, 8'h00, 13'h0200, 16'h003B, 1'b0},
      '{8'hFF, 8'h07, 8'h00, 13'h0400, 16'h0043, 1'b0},
      '{8'hFF, 8'h07, 8'h00, 13'h1000, 16'h0053, 1'b0},
      '{8'hFF, 8'h07, 8'h00, 13'h0800, 16'h005B, 1'b1},
      '{8'hFF, 8'h07, 8'h00, 13'h17FF, 16'h0043, 1'b0},
      '{8'hFF, 8'h05, 8'h00, 13'h17FF, 16'h0003, 1'b0},
      '{8'hFF, 8'h05, 8'h00, 13'h17FE, 16'h0033, 1'b0},
      '{8'hFF, 8'h05, 8'h00, 13'h16FE, 16'h000B, 1'b0},
      '{8'hFF, 8'h05, 8'h00, 13'h16FA, 16'h0013, 1'b0},
      '{8'hFF, 8'h05, 8'h00, 13'h16F8, 16'h001B, 1'b0},
      '{8'hFF, 8'h05, 8'h00, 13'h16F0, 16'h003B, 1'b0},
      '{8'hFF, 8'h05, 8'h00, 13'h14F0, 16'h0023, 1'b0},
      '{8'hFF, 8'h05, 8'h00, 13'h1430, 16'h002B, 1'b0},
      '{8'hFF, 8'h05, 8'h00, 13'h1400, 16'h0053, 1'b0},
      '{8'hBF, 8'h07, 8'h00, 13'h0104, 16'h000B, 1'b0},
      '{8'hFF, 8'h02, 8'h00, 13'h1600, 16'h0043, 1'b0},
      '{8'hFF, 8'h04, 8'h00, 13'h1200, 16'h0053, 1'b0},
      '{8'hFF, 8'h06, 8'h40, 13'h17FF, 16'h0033, 1'b1},
      '{8'hFF, 8'h07, 8'h01, 13'h0801, 16'h005B, 1'b1},
      '{8'hFF, 8'h17, 8'h00, 13'h0201, 16'h003B, 1'b1},
      '{8'hFF, 8'h47, 8'h00, 13'h1001, 16'h0053, 1'b1},
      '{8'hFF, 8'h27, 8'h00, 13'h0401, 16'h0043, 1'b1},
      '{8'hFF, 8'h07, 8'h10, 13'h0081, 16'h0023, 1'b1}
   };

   vic_ctrl i_dut (
      .mclk, .arst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
      .bit_addr, .bit_wr, .bit_wdata,
      .ext0_request(req[0]), .ext1_request(req[1]),
      .timer0_overflow_request(req[2]), .timer1_overflow_request(req[3]),
      .timer2_overflow_request(req[4]), .timer2_external_request(req[5]),
      .uart_rx_request(req[6]), .uart_tx_request(req[7]),
      .adc_request(req[8]), .serial_port_request(req[9]),
      .supply_monitor_request(req[10]), .watchdog_request(req[11]),
      .interval_counter_request(req[12]),
      .core_ready, .core_return, .irq_take, .irq_vector, .irq_take_high,
      .low_in_service, .high_in_service
   );

   vic_core_model i_core (
      .mclk, .arst_n, .stall, .ret_req, .irq_take, .irq_vector,
      .core_ready, .core_return, .pc()
   );

   always #10 mclk = ~mclk;

   task automatic conclude();
      $display("checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge mclk);
      sfr_wr = 1'b0;
      // Idle cycle so a following write never re-raises the strobe at once
      @(negedge mclk);
   endtask : wr

   task automatic bw(input logic [7:0] a, input logic v);
      bit_addr = a;
      bit_wdata = v;
      bit_wr = 1'b1;
      @(negedge mclk);
      bit_wr = 1'b0;
      @(negedge mclk);
   endtask : bw

   // Read data is registered, so it shows one edge after the address
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      sfr_addr = a;
      @(negedge mclk);
      chk("sfr_rdata", {8'h00, exp}, {8'h00, sfr_rdata});
   endtask : rd

   task automatic wait_take(input logic [15:0] vec, input logic hi);
      int n;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (irq_take !== 1'b1 && n < 20);
      if (irq_take !== 1'b1) begin
         bad_count++;
         $display("unexpected irq_take: expected 1, seen none in 20 cycles");
         conclude();
      end else begin
         chk("irq_vector", vec, irq_vector);
         chk("irq_take_high", {15'h0000, hi}, {15'h0000, irq_take_high});
         chk("level_in_service", 16'h0001,
             {15'h0000, hi ? high_in_service : low_in_service});
      end
   endtask : wait_take

   task automatic no_take(input int n);
      repeat (n) begin
         @(negedge mclk);
         chk("irq_take", 16'h0000, {15'h0000, irq_take});
      end
   endtask : no_take

   task automatic ret();
      ret_req = 1'b1;
      @(negedge mclk);
      ret_req = 1'b0;
      @(negedge mclk);
   endtask : ret

   initial begin
      repeat (5) @(negedge mclk);
      arst_n = 1'b1;
      @(negedge mclk);
      foreach (rows[i]) begin
         wr(vic_pkg::ADDR_ENABLE_MAIN, rows[i].en);
         wr(vic_pkg::ADDR_ENABLE_PRIORITY_SECONDARY, rows[i].sec);
         wr(vic_pkg::ADDR_PRIORITY_MAIN, rows[i].pri);
         req = rows[i].req;
         wait_take(rows[i].vec, rows[i].hi);
         req = 13'h0000;
         ret();
         chk("in_service", 16'h0000, {14'h0000, low_in_service, high_in_service});
      end
      // Nesting: low routine, blocked low, preempting high, then pops
      wr(vic_pkg::ADDR_ENABLE_MAIN, 8'hC3);
      wr(vic_pkg::ADDR_PRIORITY_MAIN, 8'h40);
      req = 13'h0001;
      wait_take(16'h0003, 1'b0);
      req = 13'h0004;
      no_take(8);
      req = 13'h0104;
      wait_take(16'h0033, 1'b1);
      chk("low_in_service", 16'h0001, {15'h0000, low_in_service});
      no_take(3);
      req = 13'h0004;
      ret();
      chk("in_service", 16'h0002, {14'h0000, low_in_service, high_in_service});
      ret();
      wait_take(16'h000B, 1'b0);
      req = 13'h0000;
      ret();
      // Lone request from a disabled source stays waiting
      wr(vic_pkg::ADDR_ENABLE_MAIN, 8'hBF);
      req = 13'h0100;
      no_take(4);
      // Gate cleared, then opened by a bit write while the core stalls
      wr(vic_pkg::ADDR_ENABLE_MAIN, 8'h01);
      req = 13'h0001;
      no_take(6);
      stall = 1'b1;
      bw(8'hAF, 1'b1);
      no_take(4);
      stall = 1'b0;
      wait_take(16'h0003, 1'b0);
      req = 13'h0000;
      rd(vic_pkg::ADDR_ENABLE_MAIN, 8'h81);
      bw(8'hB8, 1'b1);
      rd(vic_pkg::ADDR_PRIORITY_MAIN, 8'h41);
      wr(8'hAA, 8'hFF);
      rd(8'hAA, 8'h00);
      // Second reset with a routine still open
      wr(vic_pkg::ADDR_ENABLE_PRIORITY_SECONDARY, 8'h17);
      rd(vic_pkg::ADDR_ENABLE_PRIORITY_SECONDARY, 8'h17);
      arst_n = 1'b0;
      @(negedge mclk);
      chk("in_service", 16'h0000, {14'h0000, low_in_service, high_in_service});
      chk("irq_take", 16'h0000, {15'h0000, irq_take});
      arst_n = 1'b1;
      rd(vic_pkg::ADDR_ENABLE_MAIN, 8'h00);
      rd(vic_pkg::ADDR_ENABLE_PRIORITY_SECONDARY, 8'hA0);
      rd(vic_pkg::ADDR_PRIORITY_MAIN, 8'h00);
      conclude();
   end
endmodule : vic_ctrl_tb
`default_nettype wire
